//--- logic/uhie_pkg.sv
// Function
// - Frame count readback is read-only and shows counter's eight upper bits.
// - Frame interval counter spans 12000 USB clock counts, one frame start per ms.
// - Writing ones to the enable-clear register disables those sources in one write.
// - Writing ones to the enable-set register enables those sources in one write.
// - Set and clear registers share one enable vector and read back identically.
// - One clears or sets the enable bit; zero leaves it unchanged.
// - Enable bit 9 gates the detach event onto the interrupt.
// - Enable bit 8 gates the attach event onto the interrupt.
// - Enable bit 7 gates the buffer access error event onto the interrupt.
// - Enable bit 6 gates the upstream wake event onto the interrupt.
// - Enable bit 5 gates the downstream wake event onto the interrupt.
// - Enable bit 4 gates the host wake event onto the interrupt.
// - Enable bit 3 gates the bus reset sent event onto the interrupt.
// - Enable bit 2 gates the frame start sent event onto the interrupt.
// - Bits 15:10 and 1:0 of enables read zero; software writes zeros.
// - Each event flag stays set until software writes a one to it.
// - Frame start sent flag sets on every transmitted frame start, each ms.
// - Wake flag sets on upstream wake or detach when frames off, or attach with power.
package uhie_pkg;

    // Register indices; the byte address is four times the index.
    localparam logic [7:0] IDX_FRAME_COUNT_HIGH = 8'h12;
    localparam logic [7:0] IDX_IRQ_ENABLE_CLEAR = 8'h14;
    localparam logic [7:0] IDX_IRQ_ENABLE_SET   = 8'h18;
    localparam logic [7:0] IDX_IRQ_FLAG         = 8'h1C;
    localparam logic [7:0] IDX_HOST_CONTROL     = 8'h08;
    localparam int         ADDR_W               = 10;

    // Event bit positions, shared by the flag and enable vectors.
    localparam int BIT_DETACH    = 9;
    localparam int BIT_ATTACH    = 8;
    localparam int BIT_BUF_ERR   = 7;
    localparam int BIT_UP_WAKE   = 6;
    localparam int BIT_DOWN_WAKE = 5;
    localparam int BIT_HOST_WAKE = 4;
    localparam int BIT_RST_SENT  = 3;
    localparam int BIT_SOF_SENT  = 2;

    localparam logic [15:0] EVENT_MASK    = 16'h03FC;
    localparam logic [15:0] VEC_RESET     = 16'h0000;
    localparam logic [7:0]  FCH_RESET     = 8'h00;

    // Host control bit positions.
    localparam int BIT_FRAME_GEN_ON = 0;
    localparam int BIT_BUS_POWER_OK = 1;

    // Frame timing.
    localparam int FRAME_PERIOD_US = 1000;
    localparam int USB_CLK_KHZ     = 12000;
    localparam int FRAME_LEN       = FRAME_PERIOD_US * USB_CLK_KHZ / 1000;
    localparam int CNT_W           = 14;
    localparam int FCH_W           = 8;

    // AHB transfer type and response codes.
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic       HRESP_OKAY    = 1'b0;

    typedef struct packed {
        logic detach;
        logic attach;
        logic buf_err;
        logic up_wake;
        logic down_wake;
        logic rst_sent;
    } uhie_evt_s;

    typedef struct packed {
        logic              pending;
        logic              write;
        logic [ADDR_W-1:0] addr;
    } uhie_dphase_s;

endpackage

//--- logic/uhie_top.sv
// Chosen here: register access over AHB-Lite.
`timescale 1ns/1ns
module uhie_top #(
    parameter int FRAME_LEN = uhie_pkg::FRAME_LEN
) (
    // Clock and reset.
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    // AHB-Lite slave.
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic      [31:0]           hrdata,
    output logic                       hreadyout,
    output logic                       hresp,
    // USB clock enable and host events.
    input  wire logic                  usb_clk_en,
    input  wire uhie_pkg::uhie_evt_s   evt,
    // Interrupt and frame start.
    output logic                       irq,
    output logic                       frame_start
);

    if (FRAME_LEN < 256 || FRAME_LEN > (1 << uhie_pkg::CNT_W)) begin : g_chk
        $error("FRAME_LEN out of range for the frame counter");
    end

    localparam logic [uhie_pkg::CNT_W-1:0] CNT_TOP =
        uhie_pkg::CNT_W'(FRAME_LEN - 1);
    localparam logic [uhie_pkg::CNT_W-1:0] CNT_ZERO = '0;

    function automatic logic hit(input logic [uhie_pkg::ADDR_W-1:0] a,
                                 input logic [7:0] idx);
        hit = (a[uhie_pkg::ADDR_W-1:2] == idx) && (a[1:0] == 2'h0);
    endfunction

    logic [15:0]                 enable_ff;
    logic [15:0]                 flag_ff;
    logic [1:0]                  ctrl_ff;
    logic [uhie_pkg::CNT_W-1:0]  cnt_ff;
    uhie_pkg::uhie_dphase_s      dph_ff;
    logic [31:0]                 hrdata_ff;
    logic                        hreadyout_ff;
    logic                        hresp_ff;
    logic                        irq_ff;
    logic                        frame_start_ff;
    logic                        rd_wait_ff;

    logic                        addr_take;
    logic                        wr_go;
    logic [15:0]                 w16;
    logic [15:0]                 set_vec;
    logic [15:0]                 clr_vec;
    logic                        sof_now;
    logic [31:0]                 nxt_rdata;

    assign addr_take = hsel && hready && (htrans == uhie_pkg::HTRANS_NONSEQ);
    assign wr_go     = dph_ff.pending && dph_ff.write;
    assign w16       = hwdata[15:0] & uhie_pkg::EVENT_MASK;

    // Address phase capture; reads take one wait state.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_ff <= '0;
        end else if (hreadyout_ff) begin
            dph_ff.pending <= addr_take;
            dph_ff.write   <= hwrite;
            dph_ff.addr    <= haddr[uhie_pkg::ADDR_W-1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_ff <= 1'b1;
            rd_wait_ff   <= 1'b0;
        end else begin
            rd_wait_ff   <= hreadyout_ff && addr_take && !hwrite;
            hreadyout_ff <= !(hreadyout_ff && addr_take && !hwrite);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hresp_ff <= uhie_pkg::HRESP_OKAY;
        end else begin
            hresp_ff <= uhie_pkg::HRESP_OKAY;
        end
    end

    // Read mux; unmapped addresses read zero.
    always_comb begin
        nxt_rdata = '0;
        if (hit(dph_ff.addr, uhie_pkg::IDX_FRAME_COUNT_HIGH)) begin
            nxt_rdata[uhie_pkg::FCH_W-1:0] =
                cnt_ff[uhie_pkg::CNT_W-1 -: uhie_pkg::FCH_W];
        end else if (hit(dph_ff.addr, uhie_pkg::IDX_IRQ_ENABLE_CLEAR) ||
                     hit(dph_ff.addr, uhie_pkg::IDX_IRQ_ENABLE_SET)) begin
            nxt_rdata[15:0] = enable_ff & uhie_pkg::EVENT_MASK;
        end else if (hit(dph_ff.addr, uhie_pkg::IDX_IRQ_FLAG)) begin
            nxt_rdata[15:0] = flag_ff;
        end else if (hit(dph_ff.addr, uhie_pkg::IDX_HOST_CONTROL)) begin
            nxt_rdata[1:0] = ctrl_ff;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_ff <= '0;
        end else if (rd_wait_ff) begin
            hrdata_ff <= nxt_rdata;
        end
    end

    // Shared enable vector.
    assign set_vec = (wr_go && hit(dph_ff.addr, uhie_pkg::IDX_IRQ_ENABLE_SET)) ?
                     w16 : uhie_pkg::VEC_RESET;
    assign clr_vec = (wr_go && hit(dph_ff.addr, uhie_pkg::IDX_IRQ_ENABLE_CLEAR)) ?
                     w16 : uhie_pkg::VEC_RESET;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            enable_ff <= uhie_pkg::VEC_RESET;
        end else begin
            enable_ff <= (enable_ff & ~clr_vec) | set_vec;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_ff <= '0;
        end else if (wr_go && hit(dph_ff.addr, uhie_pkg::IDX_HOST_CONTROL)) begin
            ctrl_ff <= hwdata[1:0];
        end
    end

    // Frame interval down-counter on the USB clock enable.
    assign sof_now = usb_clk_en && (cnt_ff == CNT_ZERO) &&
                     ctrl_ff[uhie_pkg::BIT_FRAME_GEN_ON];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_ff <= CNT_ZERO;
        end else if (!ctrl_ff[uhie_pkg::BIT_FRAME_GEN_ON]) begin
            cnt_ff <= CNT_TOP;
        end else if (usb_clk_en) begin
            cnt_ff <= (cnt_ff == CNT_ZERO) ? CNT_TOP : cnt_ff - 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            frame_start_ff <= 1'b0;
        end else begin
            frame_start_ff <= sof_now;
        end
    end

    // Sticky flags; a new event wins over a simultaneous clear.
    logic [15:0] evt_vec;
    logic [15:0] flag_clr;
    always_comb begin
        evt_vec = '0;
        evt_vec[uhie_pkg::BIT_DETACH]    = evt.detach;
        evt_vec[uhie_pkg::BIT_ATTACH]    = evt.attach;
        evt_vec[uhie_pkg::BIT_BUF_ERR]   = evt.buf_err;
        evt_vec[uhie_pkg::BIT_UP_WAKE]   = evt.up_wake;
        evt_vec[uhie_pkg::BIT_DOWN_WAKE] = evt.down_wake;
        evt_vec[uhie_pkg::BIT_RST_SENT]  = evt.rst_sent;
        evt_vec[uhie_pkg::BIT_SOF_SENT]  = sof_now;
        evt_vec[uhie_pkg::BIT_HOST_WAKE] =
            ((evt.up_wake || evt.detach) && !ctrl_ff[uhie_pkg::BIT_FRAME_GEN_ON]) ||
            (evt.attach && ctrl_ff[uhie_pkg::BIT_BUS_POWER_OK]);
    end

    assign flag_clr = (wr_go && hit(dph_ff.addr, uhie_pkg::IDX_IRQ_FLAG)) ?
                      w16 : uhie_pkg::VEC_RESET;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flag_ff <= uhie_pkg::VEC_RESET;
        end else begin
            flag_ff <= (flag_ff & ~flag_clr) | evt_vec;
        end
    end

    // Per-source gating, bits 9 down to 2.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(flag_ff & enable_ff & uhie_pkg::EVENT_MASK);
        end
    end

    assign hrdata      = hrdata_ff;
    assign hreadyout   = hreadyout_ff;
    assign hresp       = hresp_ff;
    assign irq         = irq_ff;
    assign frame_start = frame_start_ff;

endmodule

//--- verif/uhie_asserts.sv
`timescale 1ns/1ns
module uhie_asserts #(
    parameter int FRAME_LEN = 12000
) (
    // Clock and reset.
    input wire logic                hclk,
    input wire logic                hresetn,
    // Bus.
    input wire logic                hsel,
    input wire logic [1:0]          htrans,
    input wire logic                hwrite,
    input wire logic                hready,
    input wire logic [31:0]         hrdata,
    input wire logic                hreadyout,
    input wire logic                hresp,
    // Events and outputs.
    input wire uhie_pkg::uhie_evt_s evt,
    input wire logic                irq,
    input wire logic                frame_start
);
    logic [15:0] gap_ff;
    logic        seen_ff;
    logic        acc;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    assign acc = hsel && hready && htrans == uhie_pkg::HTRANS_NONSEQ;
    // Counts cycles since the last frame start pulse.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gap_ff  <= 16'h0000;
            seen_ff <= 1'b0;
        end else if (frame_start) begin
            gap_ff  <= 16'h0000;
            seen_ff <= 1'b1;
        end else if (gap_ff != 16'hFFFF) begin
            gap_ff <= gap_ff + 16'h0001;
        end
    end
    chk_resp_always_okay: assert property (hresp == 1'b0)
        else $error("Response not OKAY.");
    chk_wait_one_cycle: assert property (!hreadyout |=> hreadyout)
        else $error("Wait state longer than one cycle.");
    chk_read_wait_state: assert property (acc && !hwrite |=> !hreadyout)
        else $error("Read without wait state.");
    chk_write_no_wait: assert property (acc && hwrite |=> hreadyout)
        else $error("Write with wait state.");
    chk_read_upper_zero: assert property ($rose(hreadyout) |-> hrdata[31:10] == 22'h0)
        else $error("Read data upper bits not zero.");
    chk_frame_pulse_one: assert property (frame_start |=> !frame_start)
        else $error("Frame start pulse too long.");
    chk_frame_gap_len: assert property (frame_start && seen_ff |-> gap_ff >= FRAME_LEN - 1)
        else $error("Frame starts too close.");
    chk_irq_quiet_hold: assert property (
        (!hsel && evt == 6'h00 && !frame_start) [*5] |=> $stable(irq))
        else $error("Interrupt changed without cause.");
endmodule
bind uhie_top uhie_asserts #(.FRAME_LEN(FRAME_LEN)) u_chk (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .evt(evt), .irq(irq), .frame_start(frame_start));

//--- verif/uhie_usb_dev.sv
`timescale 1ns/1ns
module uhie_usb_dev #(
    parameter int TICK_DIV = 1
) (
    // Clock and reset.
    input wire logic           hclk,
    input wire logic           hresetn,
    // Event requests from the bench.
    input wire logic [5:0]     fire,
    // Link tick and events.
    output logic               usb_clk_en,
    output uhie_pkg::uhie_evt_s evt
);
    logic [3:0] div_ff;
    assign usb_clk_en = (div_ff == 4'h0);
    // Divides the bus clock into the link tick.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_ff <= 4'h0;
        end else begin
            div_ff <= (div_ff == 4'(TICK_DIV - 1)) ? 4'h0 : div_ff + 4'h1;
        end
    end
    // Delays a request by one cycle into an event pulse of the same length.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            evt <= '0;
        end else begin
            evt <= fire;
        end
    end
endmodule

//--- verif/usb_host_irq_enable_frame_count_test.sv
`timescale 1ns/1ns
module usb_host_irq_enable_frame_count_test;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp, irq, frame_start;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
    logic [1:0] htrans = 0;
    logic [5:0] fire = 0;
    logic usb_clk_en;
    uhie_pkg::uhie_evt_s evt;
    int miscompares = 0, checks = 0, cycles = 0;
    localparam logic [7:0] SET = 8'h18, CLR = 8'h14, FLG = 8'h1C, CTL = 8'h08, FCH = 8'h12;
    always #50 hclk = ~hclk;
    uhie_top #(.FRAME_LEN(256)) u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .usb_clk_en(usb_clk_en), .evt(evt), .irq(irq), .frame_start(frame_start));
    uhie_usb_dev u_dev (.hclk(hclk), .hresetn(hresetn), .fire(fire),
        .usb_clk_en(usb_clk_en), .evt(evt));
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic ahb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1;
        htrans <= uhie_pkg::HTRANS_NONSEQ;
        hwrite <= w;
        haddr <= {22'h0, idx, 2'b00};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rdc(input logic [7:0] idx, input logic [31:0] e);
        ahb(0, idx, 0);
        chk(rd, e);
    endtask
    task automatic t_enable;
        rdc(SET, 32'h0000_0000);
        rdc(FCH, 32'h0000_0003);
        ahb(1, SET, 32'h0000_FFFF);
        rdc(SET, 32'h0000_03FC);
        rdc(CLR, 32'h0000_03FC);
        ahb(1, CLR, 32'h0000_0104);
        rdc(SET, 32'h0000_02F8);
        ahb(1, SET, 32'h0000_0000);
        rdc(CLR, 32'h0000_02F8);
        ahb(1, CLR, 32'h0000_FFFF);
        rdc(SET, 32'h0000_0000);
        $display("test enable done");
    endtask
    task automatic pulse(input int i);
        @(posedge hclk);
        fire <= 6'(1 << i);
        @(posedge hclk);
        fire <= 0;
        repeat (3) @(posedge hclk);
    endtask
    task automatic t_events;
        int eb[6] = '{3, 5, 6, 7, 8, 9};
        logic [31:0] m, e;
        for (int i = 0; i < 6; i++) begin
            m = 32'h1 << eb[i];
            e = m | ((i == 2 || i == 5) ? 32'h0000_0010 : 32'h0);
            pulse(i);
            chk(irq, 0);
            rdc(FLG, e);
            ahb(1, SET, m);
            repeat (2) @(posedge hclk);
            chk(irq, 1);
            ahb(1, FLG, e);
            repeat (2) @(posedge hclk);
            chk(irq, 0);
            ahb(1, CLR, m);
        end
        ahb(1, SET, 32'h0000_0010);
        ahb(1, CTL, 32'h0000_0002);
        pulse(4);
        chk(irq, 1);
        rdc(FLG, 32'h0000_0110);
        ahb(1, FLG, 32'h0000_0110);
        ahb(1, CLR, 32'h0000_0010);
        ahb(1, CTL, 32'h0000_0000);
        $display("test events done");
    endtask
    task automatic t_frame;
        int n = 0;
        ahb(1, SET, 32'h0000_0004);
        ahb(1, CTL, 32'h0000_0001);
        while (frame_start !== 1'b1 && n < 600) begin
            @(posedge hclk);
            n++;
        end
        n = 0;
        repeat (1024) begin
            @(posedge hclk);
            if (frame_start === 1'b1) n++;
        end
        chk(n, 4);
        chk(irq, 1);
        rdc(FLG, 32'h0000_0004);
        ahb(1, FCH, 32'h0000_FFFF);
        ahb(0, FCH, 0);
        chk(rd >> 2, 0);
        ahb(1, CTL, 32'h0000_0000);
        ahb(1, FLG, 32'h0000_0004);
        $display("test frame done");
    endtask
    task automatic complete_run;
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            complete_run;
        end
    end
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1;
        t_enable;
        t_events;
        t_frame;
        complete_run;
    end
endmodule
